/* bench/host_apb.sv */
// Host model: APB master that reads questions and writes answer bytes
`timescale 1ns/1ns
module host_apb
(
    input  wire logic        mclk_i,    // Clock
    input  wire logic        pready_i,  // Slave ready
    input  wire logic        pslverr_i, // Slave error
    input  wire logic [31:0] prdata_i,  // Read data
    output logic             psel_o,    // Select
    output logic             penable_o, // Access phase
    output logic             pwrite_o,  // Direction
    output logic      [7:0]  paddr_o,   // Byte address
    output logic      [31:0] pwdata_o   // Write data
);
    // Idle bus at time zero
    initial
    begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 8'h00;
        pwdata_o  = 32'h0;
    end

    // One transfer, held until pready is seen at an edge; no wait count assumed
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge mclk_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= w;
        paddr_o   <= a;
        pwdata_o  <= d;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        do
            @(posedge mclk_i);
        while (pready_i !== 1'b1);
        r = prdata_i;
        e = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o  <= ~d; // Released data must not look valid
    endtask
endmodule

/* bench/testbench.sv */
// Testbench: answer sequences scored against an integer model of the evaluator
`timescale 1ns/1ns
module testbench;
    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  question = 4'h0;
    logic [7:0]  exp_ans = 8'h00;
    logic        win2 = 1'b0;
    logic        win2_end = 1'b0;
    logic [1:0]  ans_cnt;
    logic        new_q, cyc_start, aerr, werr, irq;
    logic [3:0]  fail;
    int          bad_count = 0;
    int          total_checks = 0;
    int          fail_m = 0;
    int          aerr_m = 0;
    int          werr_m = 0;
    int          stat_m = 0;
    int          mask_m = 0;
    logic [11:0] tab [15] = '{12'h310, 12'h000, 12'h04f, 12'h040, 12'h110, 12'h112, 12'h300, 12'h318,
                              12'h400, 12'h40c, 12'h317, 12'h223, 12'h121, 12'h310, 12'h310};

    always #25 mclk_i = ~mclk_i;

    qa_watchdog_answer_evaluator i_qa_watchdog_answer_evaluator
    (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .question_i(question), .exp_answer_i(exp_ans),
        .win2_i(win2), .win2_end_i(win2_end), .answer_count_o(ans_cnt), .new_question_o(new_q),
        .cycle_start_o(cyc_start), .fail_count_o(fail), .answer_error_o(aerr),
        .wd_error_o(werr), .irq_o(irq)
    );

    host_apb i_host_apb
    (
        .mclk_i(mclk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata)
    );

    // ----------------------------------------
    // Checking and bus helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic summarize;
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_host_apb.xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
        i_host_apb.xfer(1'b0, a, 32'h0, rd, err);
        chk(rd, exp, m);
        chk(32'(err), 32'h0, m);
    endtask

    function automatic logic [31:0] qword();
        return {20'h0, 4'(fail_m), 1'(werr_m), 1'(aerr_m), 2'h0, question};
    endfunction

    // One watchdog cycle: s = {window one count, window two count, wrong mask}
    task automatic run_seq(input logic [11:0] s);
        int         n1;
        int         n;
        logic       good;
        logic [7:0] e;
        n1     = s[11:8];
        n      = n1 + s[7:4];
        good   = (s == 12'h310);
        mask_m = $urandom & 3;
        wr(qa_wd_pkg::IRQ_MASK_OFS, 32'(mask_m));
        for (int i = 0; i < n; i++)
        begin
            e = 8'($urandom);
            @(posedge mclk_i);
            exp_ans <= e;
            win2    <= (i >= n1); // Late answers only after window two opens
            wr(qa_wd_pkg::ANSWER_OFS, {24'h0, s[i] ? ~e : e});
            if (i < 3)
            begin
                @(posedge mclk_i);
                #1 chk(32'(ans_cnt), 32'(i + 1), "count");
            end
        end
        // Short sequences are closed by the window end pulse
        if (n < 4)
        begin
            @(posedge mclk_i);
            win2_end <= 1'b1;
            @(posedge mclk_i);
            win2_end <= 1'b0;
        end
        // Sequencing pulses stand for one cycle only, right after the verdict
        @(posedge mclk_i);
        #1;
        fail_m = good ? ((fail_m > 0) ? fail_m - 1 : 0) : ((fail_m < 15) ? fail_m + 1 : 15);
        aerr_m = !good && (s[3:0] != 4'h0);
        werr_m = !good;
        stat_m |= good ? 1 : 2;
        chk(32'(fail), 32'(fail_m), "fail");
        chk(32'(aerr), 32'(aerr_m), "aerr");
        chk(32'(werr), 32'(werr_m), "werr");
        chk(32'(new_q), 32'(good), "newq");
        chk(32'(cyc_start), 32'h1, "start");
        chk(32'(ans_cnt), 32'h0, "cnt0");
        @(posedge mclk_i);
        win2 <= 1'b0;
        if (good)
            question <= 4'($urandom);
        @(posedge mclk_i);
        rdc(qa_wd_pkg::QUESTION_OFS, qword(), "qreg");
        chk(32'(irq), 32'(|(stat_m & mask_m)), "irq");
        rdc(qa_wd_pkg::IRQ_STAT_OFS, 32'(stat_m), "stat");
        wr(qa_wd_pkg::IRQ_STAT_OFS, 32'h3);
        stat_m = 0;
        repeat (3) @(posedge mclk_i);
        #1 chk(32'(irq), 32'h0, "irqclr");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [11:0] s;
        void'($urandom(70766));
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        rdc(qa_wd_pkg::CTRL_OFS, 32'h0, "ctrl");
        rdc(qa_wd_pkg::IRQ_MASK_OFS, 32'h0, "mask");
        rdc(qa_wd_pkg::QUESTION_OFS, qword(), "q0");
        i_host_apb.xfer(1'b0, 8'h20, 32'h0, rd, err);
        chk(rd, 32'h0, "unmapped");
        chk(32'(err), 32'h1, "slverr");
        // Answers while evaluation is off must be dropped
        wr(qa_wd_pkg::CTRL_OFS, 32'h1);
        rdc(qa_wd_pkg::CTRL_OFS, 32'h1, "mode");
        wr(qa_wd_pkg::ANSWER_OFS, 32'h0);
        repeat (3) @(posedge mclk_i);
        #1 chk(32'(ans_cnt), 32'h0, "off");
        wr(qa_wd_pkg::CTRL_OFS, 32'h0);
        foreach (tab[k])
            run_seq(tab[k]);
        // Random mixes of window counts and wrong answers
        repeat (30)
        begin
            s[11:8] = 4'($urandom % 5);
            s[7:4]  = 4'($urandom % (5 - s[11:8]));
            s[3:0]  = 4'($urandom & ((1 << (s[11:8] + s[7:4])) - 1));
            run_seq(s);
        end
        summarize();
    end

    // Watchdog: far longer than the whole sequence needs
    initial
    begin
        #2_000_000;
        bad_count++;
        summarize();
    end
endmodule

/* core/qa_tally.sv */
// Answer tally: counts answers per window and decides the cycle outcome
`timescale 1ns/1ns
module qa_tally
(
    input  wire logic mclk_i,   // 20 MHz clock
    input  wire logic rst_b_i,  // Async reset, active low
    qa_eval_if.tally  ev        // Events and verdict
);

    logic [2:0]          w1_ff;
    logic [2:0]          w2_ff;
    logic                bad_ff;
    logic [1:0]          cnt_ff;
    qa_wd_pkg::verdict_t verdict_ff;
    logic                wrong_ff;
    logic [2:0]          nxt_w1;
    logic [2:0]          nxt_w2;
    logic                nxt_bad;
    logic [2:0]          total;
    logic                end_four;
    logic                end_win;

    // Saturation is not needed: a cycle closes at four answers
    function automatic logic [2:0] inc3(input logic [2:0] v, input logic b);
        inc3 = v + {2'b00, b};
    endfunction

    // Next tallies including the answer of this cycle
    always_comb
    begin
        nxt_w1   = inc3(w1_ff, ev.ans_valid & ~ev.win2);
        nxt_w2   = inc3(w2_ff, ev.ans_valid & ev.win2);
        nxt_bad  = bad_ff | (ev.ans_valid & ~ev.ans_correct);
        total    = nxt_w1 + nxt_w2;
        end_four = ev.ans_valid && (total == qa_wd_pkg::ANSWERS_PER_CYCLE);
        end_win  = ev.win2_end && !end_four;
    end

    // ------------------------------------------------------------
    // Cycle evaluation
    // ------------------------------------------------------------
    // The fourth answer wins over window end in the same cycle, so none is lost
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            w1_ff      <= 3'h0;
            w2_ff      <= 3'h0;
            bad_ff     <= 1'b0;
            cnt_ff     <= 2'h0;
            verdict_ff <= qa_wd_pkg::VD_NONE;
            wrong_ff   <= 1'b0;
        end
        else if (!ev.enable)
        begin
            w1_ff      <= 3'h0;
            w2_ff      <= 3'h0;
            bad_ff     <= 1'b0;
            cnt_ff     <= 2'h0;
            verdict_ff <= qa_wd_pkg::VD_NONE;
        end
        else if (end_four || end_win)
        begin
            w1_ff    <= 3'h0;
            w2_ff    <= 3'h0;
            bad_ff   <= 1'b0;
            cnt_ff   <= 2'h0;
            wrong_ff <= nxt_bad;
            // Only three then one, all correct, is good
            if (end_four && nxt_w1 == qa_wd_pkg::GOOD_WIN1_CNT
                && nxt_w2 == qa_wd_pkg::GOOD_WIN2_CNT && !nxt_bad)
                verdict_ff <= qa_wd_pkg::VD_GOOD;
            else
                verdict_ff <= qa_wd_pkg::VD_FAIL;
        end
        else
        begin
            w1_ff      <= nxt_w1;
            w2_ff      <= nxt_w2;
            bad_ff     <= nxt_bad;
            cnt_ff     <= total[1:0];
            verdict_ff <= qa_wd_pkg::VD_NONE;
        end
    end

    assign ev.verdict = verdict_ff;
    assign ev.wrong   = wrong_ff;
    assign ev.count   = cnt_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_four_ends_cycle: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ev.enable && end_four |=> verdict_ff != qa_wd_pkg::VD_NONE && cnt_ff == 2'h0)
        else $error("fourth answer did not close the cycle");
    a_window_end_fails: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ev.enable && end_win |=> verdict_ff == qa_wd_pkg::VD_FAIL)
        else $error("window end with few answers not failed");
    a_win1_four_fail: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ev.enable && end_four && nxt_w2 == 3'h0 |=> verdict_ff == qa_wd_pkg::VD_FAIL)
        else $error("four answers in first window not failed");

endmodule

/* core/qa_watchdog_answer_evaluator.sv */
// Question-and-answer watchdog evaluator: APB registers, flags, failure counter
// Notes on behaviour
// - Evaluation runs only while the answer mode select bit is zero.
// - Three correct then one correct: decrement, new question, clear both flags.
// - Any other sequence fails: increment counter, keep question.
// - After a failed cycle the same question is reused.
// - The fourth answer ends the cycle at once.
// - Under four answers at second window end: cycle ends and fails.
// - Four answers all in first window fail, watchdog error set.
// - One to three correct, none later: watchdog error only.
// - Early short count with extra correct late answers: watchdog error only.
// - Any incorrect answer sets answer error and watchdog error.
// - Three correct then a wrong fourth sets both flags, increments.
// - A two-bit answer count tracks answers, wrapping at the fourth.
// - Failure counter and answer error are readable in the question register.
`timescale 1ns/1ns
module qa_watchdog_answer_evaluator
(
    input  wire logic        mclk_i,         // 20 MHz clock
    input  wire logic        rst_b_i,        // Async reset, active low
    input  wire logic        psel_i,         // APB select
    input  wire logic        penable_i,      // APB access phase
    input  wire logic        pwrite_i,       // APB write
    input  wire logic [7:0]  paddr_i,        // APB byte address
    input  wire logic [31:0] pwdata_i,       // APB write data
    output logic      [31:0] prdata_o,       // APB read data
    output logic             pready_o,       // APB ready
    output logic             pslverr_o,      // APB error, unmapped
    input  wire logic [3:0]  question_i,     // Current question
    input  wire logic [7:0]  exp_answer_i,   // Expected byte for answer_count
    input  wire logic        win2_i,         // Second window open
    input  wire logic        win2_end_i,     // Second window end pulse
    output logic      [1:0]  answer_count_o, // Answers this cycle
    output logic             new_question_o, // Generate next question
    output logic             cycle_start_o,  // New watchdog cycle
    output logic      [3:0]  fail_count_o,   // Failure counter
    output logic             answer_error_o, // Answer error flag
    output logic             wd_error_o,     // Watchdog error flag
    output logic             irq_o           // Interrupt, level
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    qa_eval_if   ev();
    logic        mode_ff;
    logic [1:0]  irq_stat_ff;
    logic [1:0]  irq_mask_ff;
    logic [3:0]  fail_ff;
    logic        aerr_ff;
    logic        werr_ff;
    logic        newq_ff;
    logic        start_ff;
    logic        irq_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        setup;
    logic        wr_strobe;
    logic [1:0]  irq_set;
    logic [31:0] nxt_rdata;
    logic        nxt_err;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == qa_wd_pkg::CTRL_OFS) || (a == qa_wd_pkg::ANSWER_OFS)
                 || (a == qa_wd_pkg::QUESTION_OFS) || (a == qa_wd_pkg::IRQ_STAT_OFS)
                 || (a == qa_wd_pkg::IRQ_MASK_OFS);
    endfunction

    // Bus phases; writes land at the access edge with ready high
    assign setup     = psel_i && !penable_i;
    assign wr_strobe = psel_i && penable_i && pready_ff && pwrite_i;

    // ------------------------------------------------------------
    // Tally connection
    // ------------------------------------------------------------
    // Answers written in the other mode are dropped entirely
    assign ev.enable      = (mode_ff == qa_wd_pkg::MODE_MULTI);
    assign ev.ans_valid   = wr_strobe && (paddr_i == qa_wd_pkg::ANSWER_OFS)
                            && ev.enable;
    assign ev.ans_correct = (pwdata_i[7:0] == exp_answer_i);
    assign ev.win2        = win2_i;
    assign ev.win2_end    = win2_end_i;

    qa_tally u_tally
    (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .ev      (ev)
    );

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Mode and mask written by software
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mode_ff     <= qa_wd_pkg::MODE_RST;
            irq_mask_ff <= qa_wd_pkg::IRQ_RST;
        end
        else if (wr_strobe)
        begin
            if (paddr_i == qa_wd_pkg::CTRL_OFS)
                mode_ff <= pwdata_i[qa_wd_pkg::MODE_BIT];
            else if (paddr_i == qa_wd_pkg::IRQ_MASK_OFS)
                irq_mask_ff <= pwdata_i[1:0];
        end
    end

    // ------------------------------------------------------------
    // Failure counter
    // ------------------------------------------------------------
    // Saturates both ways so a stuck host cannot wrap it
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            fail_ff <= qa_wd_pkg::FAIL_RST;
        else if (ev.verdict == qa_wd_pkg::VD_GOOD && fail_ff != qa_wd_pkg::FAIL_RST)
            fail_ff <= fail_ff - 4'h1;
        else if (ev.verdict == qa_wd_pkg::VD_FAIL && fail_ff != qa_wd_pkg::FAIL_MAX)
            fail_ff <= fail_ff + 4'h1;
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Both flags reflect the outcome of the last finished cycle
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            aerr_ff <= 1'b0;
            werr_ff <= 1'b0;
        end
        else if (ev.verdict == qa_wd_pkg::VD_GOOD)
        begin
            aerr_ff <= 1'b0;
            werr_ff <= 1'b0;
        end
        else if (ev.verdict == qa_wd_pkg::VD_FAIL)
        begin
            aerr_ff <= ev.wrong;
            werr_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencing pulses
    // ------------------------------------------------------------
    // A new question only after a good cycle; failures keep the old one
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            newq_ff  <= 1'b0;
            start_ff <= 1'b0;
        end
        else
        begin
            newq_ff  <= (ev.verdict == qa_wd_pkg::VD_GOOD);
            start_ff <= (ev.verdict != qa_wd_pkg::VD_NONE);
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // Set beats a write-one clear in the same cycle
    assign irq_set = {ev.verdict == qa_wd_pkg::VD_FAIL, ev.verdict == qa_wd_pkg::VD_GOOD};

    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_stat_ff <= qa_wd_pkg::IRQ_RST;
        else if (wr_strobe && paddr_i == qa_wd_pkg::IRQ_STAT_OFS)
            irq_stat_ff <= (irq_stat_ff & ~pwdata_i[1:0]) | irq_set;
        else
            irq_stat_ff <= irq_stat_ff | irq_set;
    end

    // Registered one cycle behind the status bits
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data captured at setup, so ready can come from a flop
    always_comb
    begin
        nxt_rdata = 32'h0;
        nxt_err   = !is_mapped(paddr_i);
        if (paddr_i == qa_wd_pkg::CTRL_OFS)
            nxt_rdata[qa_wd_pkg::MODE_BIT] = mode_ff;
        else if (paddr_i == qa_wd_pkg::QUESTION_OFS)
        begin
            nxt_rdata[qa_wd_pkg::QUESTION_LSB +: 4] = question_i;
            nxt_rdata[qa_wd_pkg::CNT_LSB +: 2]      = ev.count;
            nxt_rdata[qa_wd_pkg::AERR_BIT]          = aerr_ff;
            nxt_rdata[qa_wd_pkg::WERR_BIT]          = werr_ff;
            nxt_rdata[qa_wd_pkg::FAIL_LSB +: 4]     = fail_ff;
        end
        else if (paddr_i == qa_wd_pkg::IRQ_STAT_OFS)
            nxt_rdata[1:0] = irq_stat_ff;
        else if (paddr_i == qa_wd_pkg::IRQ_MASK_OFS)
            nxt_rdata[1:0] = irq_mask_ff;
    end

    // One wait-free access phase: ready rises the cycle after setup
    always_ff @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= setup;
            pslverr_ff <= setup && nxt_err;
            if (setup && !pwrite_i)
                prdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata_o       = prdata_ff;
    assign pready_o       = pready_ff;
    assign pslverr_o      = pslverr_ff;
    assign answer_count_o = ev.count;
    assign new_question_o = newq_ff;
    assign cycle_start_o  = start_ff;
    assign fail_count_o   = fail_ff;
    assign answer_error_o = aerr_ff;
    assign wd_error_o     = werr_ff;
    assign irq_o          = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_good_cycle;
        ev.verdict == qa_wd_pkg::VD_GOOD;
    endsequence

    sequence s_fail_cycle;
        ev.verdict == qa_wd_pkg::VD_FAIL;
    endsequence

    a_good_clears_flags: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        s_good_cycle |=> !aerr_ff && !werr_ff)
        else $error("good cycle left a flag set");
    a_good_new_question: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        s_good_cycle |=> new_question_o && cycle_start_o)
        else $error("good cycle did not request a question");
    a_fail_same_question: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        s_fail_cycle |=> !new_question_o && cycle_start_o)
        else $error("failed cycle changed the question");
    a_fail_increments: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (s_fail_cycle and fail_ff != qa_wd_pkg::FAIL_MAX) |=> fail_ff == $past(fail_ff) + 4'h1)
        else $error("failure counter not incremented");
    a_no_underflow: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (s_good_cycle and fail_ff == qa_wd_pkg::FAIL_RST) |=> fail_ff == qa_wd_pkg::FAIL_RST)
        else $error("failure counter underflowed");
    a_wrong_sets_both: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (s_fail_cycle and ev.wrong) |=> aerr_ff && werr_ff)
        else $error("incorrect answer did not set both flags");
    a_mode_blocks: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        mode_ff != qa_wd_pkg::MODE_MULTI [*2] |-> ev.verdict == qa_wd_pkg::VD_NONE)
        else $error("evaluation ran outside multi-answer mode");

    // Counter limits and the all-correct failure path
    a_good_decrements: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (s_good_cycle and fail_ff != qa_wd_pkg::FAIL_RST) |=> fail_ff == $past(fail_ff) - 4'h1)
        else $error("failure counter not decremented");
    a_fail_saturates: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (s_fail_cycle and fail_ff == qa_wd_pkg::FAIL_MAX) |=> fail_ff == qa_wd_pkg::FAIL_MAX)
        else $error("failure counter wrapped at the top");
    a_right_keeps_aerr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (s_fail_cycle and !ev.wrong) |=> !aerr_ff && werr_ff)
        else $error("all-correct failure set the answer error");

    // ------------------------------------------------------------
    // Bus and interrupt checks
    // ------------------------------------------------------------
    // A lost status set would hide a failed cycle from software
    a_ready_after_setup: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        setup |=> pready_ff ##1 !pready_ff)
        else $error("ready not a single pulse after setup");
    a_err_with_ready: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        pslverr_ff |-> pready_ff)
        else $error("bus error without ready");
    a_fail_irq_set: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        s_fail_cycle |=> irq_stat_ff[qa_wd_pkg::IRQ_FAIL_BIT])
        else $error("failed cycle did not set its status bit");

endmodule

/* pkg/qa_eval_if.sv */
// Interface: answer events in, cycle verdict out, between bus side and tally
`timescale 1ns/1ns
interface qa_eval_if;
    logic                enable;      // Multi-answer mode active
    logic                ans_valid;   // One answer byte written
    logic                ans_correct; // That byte matched expectation
    logic                win2;        // Second response window open
    logic                win2_end;    // Second response window expires
    qa_wd_pkg::verdict_t verdict;     // Cycle outcome pulse
    logic                wrong;       // Cycle held an incorrect answer
    logic [1:0]          count;       // Answers in current cycle

    modport tally
    (
        input  enable, ans_valid, ans_correct, win2, win2_end,
        output verdict, wrong, count
    );
    modport ctrl
    (
        output enable, ans_valid, ans_correct, win2, win2_end,
        input  verdict, wrong, count
    );
endinterface

/* pkg/qa_wd_pkg.sv */
// Package: register map, field layout and constants of the answer evaluator
package qa_wd_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] ANSWER_OFS   = 8'h04;
    localparam logic [7:0] QUESTION_OFS = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_BIT     = 0;
    localparam int QUESTION_LSB = 0;
    localparam int CNT_LSB      = 4;
    localparam int AERR_BIT     = 6;
    localparam int WERR_BIT     = 7;
    localparam int FAIL_LSB     = 8;
    localparam int IRQ_GOOD_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;

    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] ANSWERS_PER_CYCLE = 3'h4;
    localparam logic [2:0] GOOD_WIN1_CNT     = 3'h3;
    localparam logic [2:0] GOOD_WIN2_CNT     = 3'h1;
    localparam logic [3:0] FAIL_MAX          = 4'hf;
    localparam logic [3:0] FAIL_RST          = 4'h0;
    localparam logic       MODE_MULTI        = 1'b0;
    localparam logic       MODE_RST          = 1'b0;
    localparam logic [1:0] IRQ_RST           = 2'h0;

    // Outcome of one watchdog cycle
    typedef enum logic [1:0]
    {
        VD_NONE = 2'b00,
        VD_GOOD = 2'b01,
        VD_FAIL = 2'b10
    } verdict_t;

endpackage
